// file: verilog/hsr_pkg.sv
// constants and types for the hot-plug signal routing block
package hsr_pkg;
  localparam int NPORT = 16;
  localparam int NGRP = 5;
  localparam int SELW = 5;
  localparam int AW = 8;
  localparam int NSIG = 5;

  localparam logic [AW-1:0] OFS_SLOT_CAP = 8'h00;
  localparam logic [AW-1:0] OFS_PORT_MODE = 8'h04;
  localparam logic [AW-1:0] OFS_GROUP_MAP = 8'h08;
  localparam logic [AW-1:0] OFS_SIG_CFG = 8'h0c;
  localparam logic [AW-1:0] OFS_ROUTE_STS = 8'h10;

  localparam logic [15:0] RST_SLOT_CAP = 16'h0000;
  localparam logic [15:0] RST_PORT_MODE = 16'h0000;
  localparam logic [24:0] RST_GROUP_MAP = 25'h1ffffff;
  localparam logic [9:0] RST_SIG_CFG = 10'h000;
  localparam int CFG_INV_IN_POS = 0;
  localparam int CFG_INV_OUT_POS = 5;
  localparam int STS_GRP_VALID_POS = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // outputs in asserted sense; bit order is fixed for the polarity masks
  typedef struct packed {
    logic attentionIndicatorOut;
    logic interlockOut;
    logic slotPowerEnableOut;
    logic powerIndicatorOut;
    logic slotResetOut;
  } hsr_out_t;

  typedef struct packed {
    logic attentionButtonIn;
    logic retentionLatchIn;
    logic presenceDetectIn;
    logic powerFaultIn;
    logic powerGoodIn;
  } hsr_in_t;

  // negated pin level with non-inverted polarity
  localparam hsr_out_t OUT_NEGATED = 5'h13;
  localparam hsr_in_t IN_NEGATED = 5'h1f;

  typedef struct packed {
    logic awvalid;
    logic [AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AW-1:0] araddr;
    logic rready;
  } hsr_axi_in_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hsr_axi_out_t;

  typedef struct packed {
    logic awHave;
    logic [AW-1:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [15:0] slotCap;
    logic [15:0] portMode;
    logic [24:0] groupMap;
    logic [9:0] sigCfg;
    hsr_in_t [NGRP-1:0] sync1;
    hsr_in_t [NGRP-1:0] sync2;
    hsr_in_t [NGRP-1:0] sync3;
    hsr_in_t [NGRP-1:0] gpioStable;
    hsr_out_t [NGRP-1:0] gpioOut;
    hsr_out_t [NPORT-1:0] expOut;
    hsr_in_t [NPORT-1:0] expInPrev;
    hsr_in_t [NPORT-1:0] ctrlIn;
    logic [NPORT-1:0] expReq;
  } hsr_state_t;
endpackage : hsr_pkg

// file: verilog/hsr_signal_routing.sv
// hot-plug signal routing between port controllers, expanders and gpio groups
`timescale 1ns/10ps

// Behaviour
// - each port's hot-plug path works only when enabled and in downstream mode
// - a port inside a partition routes exactly as in a stand-alone switch
// - the hot-plug enable bit is writable at any time, normally during reset
// - indicator outputs are driven by the port whatever the sensor location
// - expander-routed ports drive five outputs, gpio-routed ports four; every enabled port samples five inputs
// - hot-plug signal sets are indexed by port number zero to fifteen
// - enabled ports route through an expander or through a gpio group
// - only five gpio groups exist; other ports use expanders only
// - a group's port-select routes that port's signals to same-function pins
// - gpio groups carry no interlock; interlock only reaches the expander
// - a gpio-routed port ignores expander inputs and negates expander outputs
// - a group selecting no port or an absent port drives negated outputs
// - negated level follows native polarity, flipped by the invert bit
// - groups with an invalid selection ignore the invert bits
// - negated levels: attention high, interlock low, power low, indicator high, reset high
// - invert bits act on every port and on both routing paths
// - expander ports request a transaction on any input change or new output
module hsr_signal_routing
  import hsr_pkg::*;
(
  input wire logic sys_clk, // 50 MHz core clock
  input wire logic nrst, // asynchronous reset, active low
  input wire hsr_axi_in_t axiIn, // axi4-lite requests
  output hsr_axi_out_t axiOut, // axi4-lite answers
  input wire logic [NPORT-1:0] portPresent, // ports that exist in this switch
  input wire hsr_out_t [NPORT-1:0] ctrlOut, // controller outputs, asserted high
  output hsr_in_t [NPORT-1:0] ctrlIn, // sampled inputs, asserted high
  input wire hsr_in_t [NPORT-1:0] expIn, // expander input pin levels
  output hsr_out_t [NPORT-1:0] expOut, // expander output pin levels
  output logic [NPORT-1:0] expReq, // pulse: start expander transaction
  input wire hsr_in_t [NGRP-1:0] gpioIn, // gpio group input pins, asynchronous
  output hsr_out_t [NGRP-1:0] gpioOut // gpio group output pins
);

  hsr_state_t state;
  hsr_state_t next_state;

  // a port may own pins only when it exists, is enabled and faces downstream
  function automatic logic portUsable(input logic [SELW-1:0] sel, input logic [15:0] cap,
                                      input logic [15:0] mode, input logic [NPORT-1:0] pres);
    logic ok;
    ok = 1'b0;
    if (sel < SELW'(NPORT)) begin
      ok = pres[sel[3:0]] & cap[sel[3:0]] & mode[sel[3:0]];
    end
    return ok;
  endfunction : portUsable

  function automatic logic [31:0] readReg(input logic [AW-1:0] addr, input hsr_state_t s,
                                          input logic [NGRP-1:0] gv, input logic [15:0] own);
    logic [31:0] v;
    v = 32'h0;
    unique case (addr)
      OFS_SLOT_CAP: v = {16'h0, s.slotCap};
      OFS_PORT_MODE: v = {16'h0, s.portMode};
      OFS_GROUP_MAP: v = {7'h0, s.groupMap};
      OFS_SIG_CFG: v = {22'h0, s.sigCfg};
      OFS_ROUTE_STS: v = {11'h0, gv, own};
      default: v = 32'h0;
    endcase
    return v;
  endfunction : readReg

  function automatic logic addrMapped(input logic [AW-1:0] addr);
    return (addr == OFS_SLOT_CAP) || (addr == OFS_PORT_MODE) || (addr == OFS_GROUP_MAP) ||
           (addr == OFS_SIG_CFG) || (addr == OFS_ROUTE_STS);
  endfunction : addrMapped

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        v[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return v;
  endfunction : mergeBytes

  logic [NGRP-1:0] grpValid;
  logic [NGRP-1:0][3:0] grpPort;
  logic [NPORT-1:0] gpioOwned;
  logic [NPORT-1:0][2:0] ownerGrp;
  hsr_out_t invOut;
  hsr_in_t invIn;

  // which group owns which port; lowest group wins a duplicate selection
  always_comb begin
    invOut = state.sigCfg[CFG_INV_OUT_POS +: NSIG];
    invIn = state.sigCfg[CFG_INV_IN_POS +: NSIG];
    gpioOwned = '0;
    ownerGrp = '0;
    for (int g = 0; g < NGRP; g++) begin
      grpValid[g] = portUsable(state.groupMap[g*SELW +: SELW], state.slotCap,
                               state.portMode, portPresent);
      grpPort[g] = state.groupMap[g*SELW +: 4];
    end
    for (int g = NGRP - 1; g >= 0; g--) begin
      if (grpValid[g]) begin
        gpioOwned[grpPort[g]] = 1'b1;
        ownerGrp[grpPort[g]] = 3'(g);
      end
    end
  end

  logic awTake;
  logic wTake;
  logic arTake;
  logic awEff;
  logic wEff;
  logic [AW-1:0] awAddrEff;
  logic [31:0] wDataEff;
  logic [3:0] wStrbEff;
  logic [31:0] oldVal;
  logic [31:0] newVal;

  always_comb begin
    next_state = state;
    axiOut.awready = !state.awHave && !state.bValid;
    axiOut.wready = !state.wHave && !state.bValid;
    axiOut.arready = !state.rValid;
    axiOut.bvalid = state.bValid;
    axiOut.bresp = state.bResp;
    axiOut.rvalid = state.rValid;
    axiOut.rdata = state.rData;
    axiOut.rresp = state.rResp;
    awTake = axiIn.awvalid && axiOut.awready;
    wTake = axiIn.wvalid && axiOut.wready;
    arTake = axiIn.arvalid && axiOut.arready;
    awEff = state.awHave || awTake;
    wEff = state.wHave || wTake;
    awAddrEff = state.awHave ? state.awAddr : axiIn.awaddr;
    wDataEff = state.wHave ? state.wData : axiIn.wdata;
    wStrbEff = state.wHave ? state.wStrb : axiIn.wstrb;
    oldVal = readReg(awAddrEff, state, grpValid, gpioOwned);
    newVal = mergeBytes(oldVal, wDataEff, wStrbEff);

    // write: address and data may come in either order
    if (awTake) begin
      next_state.awHave = 1'b1;
      next_state.awAddr = axiIn.awaddr;
    end
    if (wTake) begin
      next_state.wHave = 1'b1;
      next_state.wData = axiIn.wdata;
      next_state.wStrb = axiIn.wstrb;
    end
    if (awEff && wEff && !state.bValid) begin
      next_state.awHave = 1'b0;
      next_state.wHave = 1'b0;
      next_state.bValid = 1'b1;
      next_state.bResp = addrMapped(awAddrEff) ? RESP_OKAY : RESP_DECERR;
      unique case (awAddrEff)
        OFS_SLOT_CAP: next_state.slotCap = newVal[15:0];
        OFS_PORT_MODE: next_state.portMode = newVal[15:0];
        OFS_GROUP_MAP: next_state.groupMap = newVal[24:0];
        OFS_SIG_CFG: next_state.sigCfg = newVal[9:0];
        default: next_state.bResp = addrMapped(awAddrEff) ? RESP_OKAY : RESP_DECERR;
      endcase
    end
    if (state.bValid && axiIn.bready) begin
      next_state.bValid = 1'b0;
    end
    if (state.rValid && axiIn.rready) begin
      next_state.rValid = 1'b0;
    end
    if (arTake) begin
      next_state.rValid = 1'b1;
      next_state.rData = readReg(axiIn.araddr, state, grpValid, gpioOwned);
      next_state.rResp = addrMapped(axiIn.araddr) ? RESP_OKAY : RESP_DECERR;
    end

    // gpio inputs: three stages, a change counts once stages two and three agree
    next_state.sync1 = gpioIn;
    next_state.sync2 = state.sync1;
    next_state.sync3 = state.sync2;
    for (int g = 0; g < NGRP; g++) begin
      for (int b = 0; b < NSIG; b++) begin
        if (state.sync2[g][b] == state.sync3[g][b]) begin
          next_state.gpioStable[g][b] = state.sync3[g][b];
        end
      end
    end

    // gpio group outputs
    for (int g = 0; g < NGRP; g++) begin
      if (grpValid[g]) begin
        next_state.gpioOut[g] = ctrlOut[grpPort[g]] ^ OUT_NEGATED ^ invOut;
      end else begin
        next_state.gpioOut[g] = OUT_NEGATED;
      end
      // the interlock pin does not exist on a group; it sits at its idle level
      next_state.gpioOut[g].interlockOut = OUT_NEGATED.interlockOut;
    end

    // per port: expander outputs, sampled inputs, transaction requests
    for (int p = 0; p < NPORT; p++) begin
      next_state.expInPrev[p] = expIn[p];
      next_state.expReq[p] = 1'b0;
      if (state.slotCap[p] && state.portMode[p] && !gpioOwned[p]) begin
        next_state.expOut[p] = ctrlOut[p] ^ OUT_NEGATED ^ invOut;
        next_state.ctrlIn[p] = expIn[p] ^ IN_NEGATED ^ invIn;
        if ((next_state.expOut[p] != state.expOut[p]) || (expIn[p] != state.expInPrev[p])) begin
          next_state.expReq[p] = 1'b1;
        end
      end else if (gpioOwned[p]) begin
        next_state.expOut[p] = OUT_NEGATED ^ invOut;
        next_state.ctrlIn[p] = state.gpioStable[ownerGrp[p]] ^ IN_NEGATED ^ invIn;
      end else begin
        next_state.expOut[p] = OUT_NEGATED ^ invOut;
        next_state.ctrlIn[p] = '0;
      end
    end
  end

  assign ctrlIn = state.ctrlIn;
  assign expOut = state.expOut;
  assign expReq = state.expReq;
  assign gpioOut = state.gpioOut;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= '0;
      state.slotCap <= RST_SLOT_CAP;
      state.portMode <= RST_PORT_MODE;
      state.groupMap <= RST_GROUP_MAP;
      state.sigCfg <= RST_SIG_CFG;
      state.gpioOut <= {NGRP{OUT_NEGATED}};
      state.expOut <= {NPORT{OUT_NEGATED}};
      state.sync1 <= {NGRP{IN_NEGATED}};
      state.sync2 <= {NGRP{IN_NEGATED}};
      state.sync3 <= {NGRP{IN_NEGATED}};
      state.gpioStable <= {NGRP{IN_NEGATED}};
      state.expInPrev <= {NPORT{IN_NEGATED}};
    end else begin
      state <= next_state;
    end
  end

endmodule : hsr_signal_routing

// file: tb/hsr_monitor.sv
// port-level assertions for the hot-plug signal routing block
`timescale 1ns/10ps
module hsr_monitor
  import hsr_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire logic nrst, // reset, active low
  input wire hsr_axi_in_t axiIn, // bus requests
  input wire hsr_axi_out_t axiOut, // bus answers
  input wire logic [NPORT-1:0] portPresent, // existing ports
  input wire hsr_out_t [NPORT-1:0] ctrlOut, // controller outputs
  input wire hsr_in_t [NPORT-1:0] ctrlIn, // sampled inputs
  input wire hsr_in_t [NPORT-1:0] expIn, // expander inputs
  input wire hsr_out_t [NPORT-1:0] expOut, // expander outputs
  input wire logic [NPORT-1:0] expReq, // expander requests
  input wire hsr_in_t [NGRP-1:0] gpioIn, // group inputs
  input wire hsr_out_t [NGRP-1:0] gpioOut // group outputs
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_wr;
    axiIn.awvalid && axiOut.awready && axiIn.wvalid && axiOut.wready;
  endsequence
  sequence s_rd;
    axiIn.arvalid && axiOut.arready;
  endsequence
  AST_NO_ILOCK: assert property ((gpioOut & {NGRP{5'h08}}) == '0)
    else $error("group drives interlock");
  AST_ABSENT_NEG: assert property (portPresent == '0 |=> gpioOut == {NGRP{OUT_NEGATED}})
    else $error("group with no port not negated");
  // idle controllers: every port shows the same negated pattern whatever the routing
  AST_EXP_SAME: assert property (ctrlOut == '0 |=> expOut == {NPORT{expOut[0]}})
    else $error("idle expander outputs differ");
  for (genvar p = 0; p < NPORT; p++) begin : g_req
    AST_REQ_CAUSE: assert property (expReq[p] && $past(nrst, 2) |->
      $changed(expOut[p]) || $past(expIn[p]) != $past(expIn[p], 2))
      else $error("expander request without cause");
  end
  AST_WR_RESP: assert property (s_wr |=> axiOut.bvalid)
    else $error("write not answered");
  AST_B_HOLD: assert property (axiOut.bvalid && !axiIn.bready |=>
    axiOut.bvalid && $stable(axiOut.bresp))
    else $error("write answer dropped");
  AST_RD_RESP: assert property (s_rd |=> axiOut.rvalid)
    else $error("read not answered");
  AST_R_HOLD: assert property (axiOut.rvalid && !axiIn.rready |=>
    axiOut.rvalid && $stable(axiOut.rdata))
    else $error("read answer dropped");
endmodule : hsr_monitor

// file: tb/hsr_slot_model.sv
// slot-side model driving expander and group input pins
`timescale 1ns/10ps
module hsr_slot_model
  import hsr_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire hsr_in_t [NPORT-1:0] slotSense, // slot sensors, asserted high
  input wire hsr_in_t [NGRP-1:0] grpSense, // group sensors, asserted high
  output hsr_in_t [NPORT-1:0] expIn, // expander pin levels
  output hsr_in_t [NGRP-1:0] gpioIn // group pin levels
);
  initial begin
    expIn = {NPORT{IN_NEGATED}};
    gpioIn = {NGRP{IN_NEGATED}};
  end
  // sensors are active low; pins move just after the edge like real logic
  always @(posedge sys_clk) begin
    expIn <= slotSense ^ {NPORT{IN_NEGATED}};
    gpioIn <= grpSense ^ {NGRP{IN_NEGATED}};
  end
endmodule : hsr_slot_model

// file: tb/test_hotplug_signal_routing.sv
// self-checking bench for the hot-plug signal routing block
`timescale 1ns/10ps
module test_hotplug_signal_routing;
  import hsr_pkg::*;
  logic sys_clk = 0;
  logic nrst = 0;
  hsr_axi_in_t axiIn = '0;
  hsr_axi_out_t axiOut;
  logic [NPORT-1:0] portPresent = '1;
  hsr_out_t [NPORT-1:0] ctrlOut = '0;
  hsr_out_t [NPORT-1:0] expOut;
  hsr_in_t [NPORT-1:0] ctrlIn, expIn, slotSense = '0;
  hsr_in_t [NGRP-1:0] gpioIn, grpSense = '0;
  hsr_out_t [NGRP-1:0] gpioOut;
  logic [NPORT-1:0] expReq;
  int fail_count = 0, compares = 0, cyc = 0;
  logic [15:0] lfsr = 16'h9f4a;
  logic [15:0] cap, mode;
  logic [31:0] rd;
  logic [9:0] cfg;
  logic [3:0] s;
  logic [1:0] resp;
  logic en;
  logic [NPORT-1:0] reqMask;
  always #10 sys_clk = ~sys_clk;
  hsr_signal_routing dut_u (.sys_clk(sys_clk), .nrst(nrst), .axiIn(axiIn), .axiOut(axiOut),
    .portPresent(portPresent), .ctrlOut(ctrlOut), .ctrlIn(ctrlIn), .expIn(expIn),
    .expOut(expOut), .expReq(expReq), .gpioIn(gpioIn), .gpioOut(gpioOut));
  hsr_slot_model slot_u (.sys_clk(sys_clk), .slotSense(slotSense), .grpSense(grpSense),
    .expIn(expIn), .gpioIn(gpioIn));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  function automatic hsr_out_t pin_out(hsr_out_t a, logic [4:0] inv);
    return a ^ OUT_NEGATED ^ inv;
  endfunction : pin_out
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task stop_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  // readys are looked at on the falling edge, where nothing is moving
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ra, rw, b;
    ta = 0;
    tw = 0;
    @(posedge sys_clk);
    axiIn.awvalid <= 1;
    axiIn.awaddr <= a;
    axiIn.wvalid <= 1;
    axiIn.wdata <= d;
    axiIn.wstrb <= 4'hf;
    while (!(ta && tw)) begin
      @(negedge sys_clk);
      ra = axiOut.awready && !ta;
      rw = axiOut.wready && !tw;
      @(posedge sys_clk);
      if (ra) axiIn.awvalid <= 0;
      if (rw) axiIn.wvalid <= 0;
      ta |= ra;
      tw |= rw;
    end
    do begin
      @(negedge sys_clk);
      b = axiOut.bvalid;
      @(posedge sys_clk);
    end while (!b);
    axiIn.bready <= 1;
    do begin
      @(negedge sys_clk);
      b = axiOut.bvalid;
      resp = axiOut.bresp;
      @(posedge sys_clk);
    end while (!b);
    axiIn.bready <= 0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a);
    logic b;
    @(posedge sys_clk);
    axiIn.arvalid <= 1;
    axiIn.araddr <= a;
    do begin
      @(negedge sys_clk);
      b = axiOut.arready;
      @(posedge sys_clk);
    end while (!b);
    axiIn.arvalid <= 0;
    do begin
      @(negedge sys_clk);
      b = axiOut.rvalid;
      @(posedge sys_clk);
    end while (!b);
    axiIn.rready <= 1;
    do begin
      @(negedge sys_clk);
      b = axiOut.rvalid;
      rd = axiOut.rdata;
      resp = axiOut.rresp;
      @(posedge sys_clk);
    end while (!b);
    axiIn.rready <= 0;
  endtask : axi_rd
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1;
    axi_rd(OFS_SLOT_CAP);
    check(rd, 32'(RST_SLOT_CAP));
    axi_rd(OFS_GROUP_MAP);
    check(rd, 32'(RST_GROUP_MAP));
    axi_rd(8'h40);
    check(resp, RESP_DECERR);
    check(gpioOut, {NGRP{OUT_NEGATED}});
    $display("reset test done");
    for (int i = 0; i < 40; i++) begin
      s = 4'(rnd());
      cap = (rnd() | (16'h1 << s)) & ~(16'h1 << (s ^ 4'h1));
      mode = (rnd() | (16'h1 << s)) & ~(16'h1 << (s ^ 4'h2));
      cfg = 10'(rnd());
      axi_wr(OFS_SLOT_CAP, 32'(cap));
      axi_wr(OFS_PORT_MODE, 32'(mode));
      // group 0 valid, 1 no port, 2 absent, 3 not downstream, 4 out of range
      axi_wr(OFS_GROUP_MAP, 32'({1'b1, 4'(rnd()), 1'b0, s ^ 4'h2, 1'b0, s ^ 4'h1,
        5'h1f, 1'b0, s}));
      axi_wr(OFS_SIG_CFG, 32'(cfg));
      portPresent <= ~(16'h1 << (s ^ 4'h1));
      for (int p = 0; p < NPORT; p++) begin
        ctrlOut[p] <= 5'(rnd());
        slotSense[p] <= 5'(rnd());
      end
      grpSense <= 25'({rnd(), rnd()});
      settle(10);
      check(gpioOut[0], pin_out(ctrlOut[s], cfg[9:5]) & 5'h17);
      check(gpioOut[4:1], {4{OUT_NEGATED}});
      for (int p = 0; p < NPORT; p++) begin
        en = cap[p] && mode[p] && p != s;
        reqMask[p] = en;
        check(expOut[p], pin_out(en ? ctrlOut[p] : 5'h00, cfg[9:5]));
        check(ctrlIn[p], en ? slotSense[p] ^ cfg[4:0] :
          p == s ? grpSense[0] ^ cfg[4:0] : 5'h00);
      end
      check(expReq, 32'h0);
      // one input edge on every port: only expander-routed ports may ask for a transaction
      @(posedge sys_clk);
      for (int p = 0; p < NPORT; p++) begin
        slotSense[p].powerGoodIn <= !slotSense[p].powerGoodIn;
      end
      settle(2);
      check(expReq, 32'(reqMask));
      settle(1);
      check(expReq, 32'h0);
    end
    $display("routing test done");
    axi_wr(8'h44, 32'h0);
    check(resp, RESP_DECERR);
    ctrlOut <= '0;
    portPresent <= '0;
    settle(3);
    check(gpioOut, {NGRP{OUT_NEGATED}});
    axi_rd(OFS_SIG_CFG);
    check(rd, 32'(cfg));
    $display("absent port test done");
    stop_test();
  end
endmodule : test_hotplug_signal_routing
bind hsr_signal_routing hsr_monitor mon_u (.sys_clk(sys_clk), .nrst(nrst), .axiIn(axiIn),
  .axiOut(axiOut), .portPresent(portPresent), .ctrlOut(ctrlOut), .ctrlIn(ctrlIn),
  .expIn(expIn), .expOut(expOut), .expReq(expReq), .gpioIn(gpioIn), .gpioOut(gpioOut));
